/* File: shared/timer16_defs.svh */
// Register indices, field positions and fixed values for the timer compare/capture block
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH
`define IDX_CMP_LAST 6'h0B
`define IDX_ICR1_LO 6'h0C
`define IDX_ICR1_HI 6'h0D
`define IDX_ICR3_LO 6'h0E
`define IDX_ICR3_HI 6'h0F
`define IDX_MASK 6'h10
`define IDX_EXT_MASK 6'h11
`define IDX_FLAGS 6'h12
`define IDX_EXT_FLAGS 6'h13
`define IDX_CAP_CTRL 6'h14
`define IDX_TOGGLE_EN 6'h15
`define MAIN_VALID 8'h3C
`define EXT_VALID 8'h3F
`define BIT_CAPTURE 5
`define BIT_CMP_A 4
`define BIT_CMP_B 3
`define BIT_OVF 2
`define BIT_CMP_C3 1
`define BIT_CMP_C1 0
`define CTRL_T1_RISE 0
`define CTRL_T3_RISE 1
`define CTRL_T1_ALT 2
`define CTRL_T1_TOP 3
`define CTRL_T3_TOP 4
`define TOP_MAX 16'hFFFF
`define NUM_CMP 6
`define CMP_PER_TIMER 3
`define HTRANS_NONSEQ 2'h2
`endif

/* File: shared/timer16_pkg.sv */
// Types for the timer compare/capture block
package timer16_pkg;
  typedef logic [15:0] word16_t;

  typedef struct packed {
    logic match;
  } cmp_state_t;

  typedef struct packed {
    logic [1:0] pinSync;
    logic [1:0] altSync;
    logic last;
    word16_t value;
    logic event1;
  } cap_state_t;

  typedef struct packed {
    logic [1:0] legacySync;
    word16_t [5:0] cmpValue;
    logic [7:0] temp;
    logic [7:0] maskMain;
    logic [7:0] maskExt;
    logic [7:0] flagsMain;
    logic [7:0] flagsExt;
    logic [7:0] capCtrl;
    logic [7:0] toggleEn;
    logic wrPending;
    logic [5:0] wrIndex;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] irqLinesMain;
    logic [7:0] irqLinesExt;
    logic irq;
    logic [5:0] compareOutputPin;
    word16_t t1Top;
    word16_t t3Top;
  } top_state_t;
endpackage

/* File: src/compare_match.sv */
// One compare channel: flags equality of count and compare value on a timer tick
module compare_match
  import timer16_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clockEnable,
  input wire logic tick,
  input wire timer16_pkg::word16_t count,
  input wire timer16_pkg::word16_t value,
  output logic match
);
  import timer16_pkg::*;

  cmp_state_t st;
  cmp_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.match = tick && (count == value); // R01
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clockEnable) begin
      st <= next_st;
    end
  end

  assign match = st.match;

  match_seen_a: assert property ( // R01
    @(posedge clock) disable iff (!rst_b)
    clockEnable && tick && (count == value) |=> match)
    else $error("Compare equality on a tick did not raise match");

  match_only_a: assert property ( // R02
    @(posedge clock) disable iff (!rst_b)
    clockEnable && !(tick && (count == value)) |=> !match)
    else $error("Match raised without equality");
endmodule

/* File: src/capture_unit.sv */
// Input capture: synchronises the trigger, detects the chosen edge, latches the count
module capture_unit
  import timer16_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clockEnable,
  input wire logic pinRaw,
  input wire logic altRaw,
  input wire logic useAlt,
  input wire logic risingEdge,
  input wire logic useAsTop,
  input wire logic tick,
  input wire timer16_pkg::word16_t count,
  output timer16_pkg::word16_t value,
  output logic captureEvent
);
  import timer16_pkg::*;

  cap_state_t st;
  cap_state_t next_st;
  logic sel;
  logic edgeSeen;

  always_comb begin
    next_st = st;
    next_st.pinSync = {st.pinSync[0], pinRaw};
    next_st.altSync = {st.altSync[0], altRaw};
    sel = useAlt ? st.altSync[1] : st.pinSync[1]; // R06
    next_st.last = sel;
    edgeSeen = risingEdge ? (sel && !st.last) : (!sel && st.last);
    next_st.event1 = 1'b0;
    if (useAsTop) begin
      // Pin is disconnected; the flag marks the counter reaching top
      next_st.event1 = tick && (count == st.value); // R07
    end else if (edgeSeen) begin
      next_st.value = count; // R05
      next_st.event1 = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clockEnable) begin
      st <= next_st;
    end
  end

  assign value = st.value;
  assign captureEvent = st.event1;

  capture_load_a: assert property ( // R05
    @(posedge clock) disable iff (!rst_b)
    captureEvent && !$past(useAsTop) && $past(clockEnable) |-> value == $past(count))
    else $error("Capture value differs from count at the event");
endmodule

/* File: src/timer16_compare_capture.sv */
// Compare/capture registers, shared high-byte latch and interrupt masks of two 16-bit timers
// Notes on behaviour
// (R01) Six compare values are matched against the running count on every timer tick.
// (R02) A match sets a compare flag and can toggle its compare output pin.
// (R03) Compare high byte goes to the latch; low-byte write commits both bytes.
// (R04) One high-byte latch serves every 16-bit register of both timers.
// (R05) Capture register loads the count on a qualifying capture pin edge.
// (R06) First timer may take its capture trigger from the analog comparator.
// (R07) Capture register can be selected as the counter top value.
// (R08) Reading capture low byte copies its high byte into the shared latch.
// (R09) Mask bit 5 gates first timer capture interrupt.
// (R10) Mask bit 4 gates first timer compare A interrupt.
// (R11) Mask bit 3 gates first timer compare B interrupt.
// (R12) Mask bit 2 gates first timer overflow interrupt.
// (R13) Mask bits of other timers are stored and read back.
// (R14) Extended mask bits 7:6 read zero; software writes zero.
// (R15) Extended mask is absent in legacy compatibility mode.
// (R16) Extended mask bit 5 gates second timer capture interrupt.
// (R17) Extended bits 4..0 gate T3 cmp A, cmp B, overflow, cmp C, T1 cmp C.
// (R18) Flags clear on vector execution or on a written one.
// (R19) Each request line is mask AND flag; the core applies global gating.
`include "timer16_defs.svh"

module timer16_compare_capture
  import timer16_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clockEnable,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic legacyMode,
  input wire timer16_pkg::word16_t t1Count,
  input wire timer16_pkg::word16_t t3Count,
  input wire logic t1Tick,
  input wire logic t3Tick,
  input wire logic t1Overflow,
  input wire logic t3Overflow,
  input wire logic t1CapturePin,
  input wire logic t3CapturePin,
  input wire logic comparatorOut,
  input wire logic [7:0] vectorAckMain,
  input wire logic [7:0] vectorAckExt,
  output logic [5:0] compareOutputPin,
  output timer16_pkg::word16_t t1TopValue,
  output timer16_pkg::word16_t t3TopValue,
  output logic [7:0] irqLinesMain,
  output logic [7:0] irqLinesExt,
  output logic irq
);
  import timer16_pkg::*;

  top_state_t st;
  top_state_t next_st;
  logic [5:0] cmpMatch;
  word16_t icr1;
  word16_t icr3;
  logic t1CapEvent;
  logic t3CapEvent;
  logic legacyOn;
  logic addrPhase;
  logic [5:0] addrIndex;
  logic [7:0] wdata;
  logic [7:0] rd;
  logic [7:0] evMain;
  logic [7:0] evExt;
  logic [7:0] clrMain;
  logic [7:0] clrExt;
  logic [7:0] extMaskSeen;

  genvar g;
  generate
    for (g = 0; g < `NUM_CMP; g++) begin : gen_cmp
      compare_match u_cmp (
        .clock(clock),
        .rst_b(rst_b),
        .clockEnable(clockEnable),
        .tick(g < `CMP_PER_TIMER ? t1Tick : t3Tick),
        .count(g < `CMP_PER_TIMER ? t1Count : t3Count),
        .value(st.cmpValue[g]),
        .match(cmpMatch[g])
      );
    end
  endgenerate

  capture_unit u_cap1 (
    .clock(clock),
    .rst_b(rst_b),
    .clockEnable(clockEnable),
    .pinRaw(t1CapturePin),
    .altRaw(comparatorOut),
    .useAlt(st.capCtrl[`CTRL_T1_ALT]),
    .risingEdge(st.capCtrl[`CTRL_T1_RISE]),
    .useAsTop(st.capCtrl[`CTRL_T1_TOP]),
    .tick(t1Tick),
    .count(t1Count),
    .value(icr1),
    .captureEvent(t1CapEvent)
  );

  capture_unit u_cap3 (
    .clock(clock),
    .rst_b(rst_b),
    .clockEnable(clockEnable),
    .pinRaw(t3CapturePin),
    .altRaw(1'b0),
    .useAlt(1'b0),
    .risingEdge(st.capCtrl[`CTRL_T3_RISE]),
    .useAsTop(st.capCtrl[`CTRL_T3_TOP]),
    .tick(t3Tick),
    .count(t3Count),
    .value(icr3),
    .captureEvent(t3CapEvent)
  );

  assign legacyOn = st.legacySync[1];
  assign addrPhase = hsel && hready && (htrans == `HTRANS_NONSEQ);
  assign addrIndex = haddr[7:2];
  assign wdata = hwdata[7:0];
  assign extMaskSeen = legacyOn ? 8'h00 : st.maskExt; // R15

  always_comb begin
    next_st = st;
    next_st.legacySync = {st.legacySync[0], legacyMode};
    next_st.hreadyout = 1'b1;
    next_st.hresp = 1'b0;

    evMain = 8'h00;
    evMain[`BIT_CAPTURE] = t1CapEvent; // R09
    evMain[`BIT_CMP_A] = cmpMatch[0]; // R10
    evMain[`BIT_CMP_B] = cmpMatch[1]; // R11
    evMain[`BIT_OVF] = t1Overflow; // R12
    evExt = 8'h00;
    evExt[`BIT_CAPTURE] = t3CapEvent; // R16
    evExt[`BIT_CMP_A] = cmpMatch[3];
    evExt[`BIT_CMP_B] = cmpMatch[4];
    evExt[`BIT_OVF] = t3Overflow;
    evExt[`BIT_CMP_C3] = cmpMatch[5];
    evExt[`BIT_CMP_C1] = cmpMatch[2];
    clrMain = vectorAckMain;
    clrExt = vectorAckExt;

    // Address phase: answer a read next cycle, remember a write for the data phase
    rd = 8'h00;
    next_st.wrPending = addrPhase && hwrite;
    if (addrPhase) begin
      next_st.wrIndex = addrIndex;
    end
    if (addrPhase && !hwrite) begin
      if (addrIndex <= `IDX_CMP_LAST) begin
        rd = addrIndex[0] ? st.cmpValue[addrIndex[3:1]][15:8]
                          : st.cmpValue[addrIndex[3:1]][7:0];
      end else begin
        case (addrIndex)
          `IDX_ICR1_LO: begin
            rd = icr1[7:0];
            next_st.temp = icr1[15:8]; // R08
          end
          `IDX_ICR3_LO: begin
            rd = icr3[7:0];
            next_st.temp = icr3[15:8]; // R08
          end
          `IDX_ICR1_HI, `IDX_ICR3_HI: rd = st.temp; // R08
          `IDX_MASK: rd = st.maskMain; // R13
          `IDX_EXT_MASK: rd = extMaskSeen; // R14
          `IDX_FLAGS: rd = st.flagsMain;
          `IDX_EXT_FLAGS: rd = st.flagsExt;
          `IDX_CAP_CTRL: rd = st.capCtrl;
          `IDX_TOGGLE_EN: rd = st.toggleEn;
          default: rd = 8'h00;
        endcase
      end
    end
    next_st.hrdata = 32'(rd);

    // Data phase of a write
    if (st.wrPending) begin
      if (st.wrIndex <= `IDX_CMP_LAST) begin
        if (st.wrIndex[0]) begin
          next_st.temp = wdata; // R04
        end else begin
          next_st.cmpValue[st.wrIndex[3:1]] = {st.temp, wdata}; // R03
        end
      end else begin
        case (st.wrIndex)
          `IDX_ICR1_HI, `IDX_ICR3_HI: next_st.temp = wdata; // R04
          `IDX_MASK: next_st.maskMain = wdata; // R13
          `IDX_EXT_MASK: begin
            if (!legacyOn) begin
              next_st.maskExt = wdata & `EXT_VALID; // R14
            end
          end
          `IDX_FLAGS: clrMain = clrMain | wdata; // R18
          `IDX_EXT_FLAGS: clrExt = clrExt | wdata; // R18
          `IDX_CAP_CTRL: next_st.capCtrl = wdata;
          `IDX_TOGGLE_EN: next_st.toggleEn = wdata;
          default: ;
        endcase
      end
    end

    // A new event wins over a clear in the same cycle
    next_st.flagsMain = ((st.flagsMain & ~clrMain) | evMain) & `MAIN_VALID; // R18
    next_st.flagsExt = ((st.flagsExt & ~clrExt) | evExt) & `EXT_VALID; // R18

    next_st.irqLinesMain = st.flagsMain & st.maskMain & `MAIN_VALID; // R19
    next_st.irqLinesExt = st.flagsExt & extMaskSeen; // R17
    next_st.irq = |{next_st.irqLinesMain, next_st.irqLinesExt}; // R19

    for (int i = 0; i < `NUM_CMP; i++) begin
      if (cmpMatch[i] && st.toggleEn[i]) begin
        next_st.compareOutputPin[i] = !st.compareOutputPin[i]; // R02
      end
    end

    next_st.t1Top = st.capCtrl[`CTRL_T1_TOP] ? icr1 : `TOP_MAX; // R07
    next_st.t3Top = st.capCtrl[`CTRL_T3_TOP] ? icr3 : `TOP_MAX; // R07
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st <= '0;
      st.hreadyout <= 1'b1;
      st.t1Top <= `TOP_MAX;
      st.t3Top <= `TOP_MAX;
    end else if (clockEnable) begin
      st <= next_st;
    end
  end

  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;
  assign hrdata = st.hrdata;
  assign compareOutputPin = st.compareOutputPin;
  assign t1TopValue = st.t1Top;
  assign t3TopValue = st.t3Top;
  assign irqLinesMain = st.irqLinesMain;
  assign irqLinesExt = st.irqLinesExt;
  assign irq = st.irq;

  latch_pair_a: assert property ( // R03
    @(posedge clock) disable iff (!rst_b)
    clockEnable && st.wrPending && st.wrIndex <= `IDX_CMP_LAST && !st.wrIndex[0]
    |=> st.cmpValue[$past(st.wrIndex[3:1])] == {$past(st.temp), $past(hwdata[7:0])})
    else $error("Compare low write did not commit latch and low byte");

  shared_latch_a: assert property ( // R04
    @(posedge clock) disable iff (!rst_b)
    clockEnable && st.wrPending && st.wrIndex <= `IDX_CMP_LAST && st.wrIndex[0]
    |=> st.temp == $past(hwdata[7:0]) && st.cmpValue == $past(st.cmpValue))
    else $error("High byte write did not land only in the shared latch");

  capture_coherent_a: assert property ( // R08
    @(posedge clock) disable iff (!rst_b)
    clockEnable && addrPhase && !hwrite && addrIndex == `IDX_ICR1_LO
    |=> st.temp == $past(icr1[15:8]) && hrdata[7:0] == $past(icr1[7:0]))
    else $error("Capture low read did not latch its high byte");

  t1_capture_irq_a: assert property ( // R09
    @(posedge clock) disable iff (!rst_b)
    clockEnable && st.flagsMain[`BIT_CAPTURE] && st.maskMain[`BIT_CAPTURE]
    |=> irqLinesMain[`BIT_CAPTURE] ##0 irq)
    else $error("Capture request not raised");

  t1_compare_irq_a: assert property ( // R10
    @(posedge clock) disable iff (!rst_b)
    clockEnable |=> irqLinesMain[`BIT_CMP_A:`BIT_OVF] ==
      $past(st.flagsMain[`BIT_CMP_A:`BIT_OVF] & st.maskMain[`BIT_CMP_A:`BIT_OVF]))
    else $error("Compare or overflow request line wrong");

  ext_reserved_a: assert property ( // R14
    @(posedge clock) disable iff (!rst_b)
    st.maskExt[7:6] == 2'h0 && irqLinesExt[7:6] == 2'h0)
    else $error("Reserved extended mask bits not zero");

  legacy_hides_a: assert property ( // R15
    @(posedge clock) disable iff (!rst_b)
    clockEnable && legacyOn ##1 legacyOn |-> irqLinesExt == 8'h00)
    else $error("Extended requests active in legacy mode");

  flag_set_wins_a: assert property ( // R18
    @(posedge clock) disable iff (!rst_b)
    clockEnable && t1CapEvent && vectorAckMain[`BIT_CAPTURE]
    |=> st.flagsMain[`BIT_CAPTURE])
    else $error("Capture event lost against a clear");

  flag_clear_a: assert property ( // R18
    @(posedge clock) disable iff (!rst_b)
    clockEnable && vectorAckExt[`BIT_CAPTURE] && !t3CapEvent
    |=> !st.flagsExt[`BIT_CAPTURE])
    else $error("Vector acknowledge did not clear the flag");

  top_select_a: assert property ( // R07
    @(posedge clock) disable iff (!rst_b)
    clockEnable && st.capCtrl[`CTRL_T1_TOP] |=> t1TopValue == $past(icr1))
    else $error("Top value does not follow the capture register");

  compare_flag_a: assert property ( // R10
    @(posedge clock) disable iff (!rst_b)
    clockEnable && cmpMatch[0]
    |=> st.flagsMain[`BIT_CMP_A])
    else $error("Compare A match did not set its flag");

  compare_c_flag_a: assert property ( // R17
    @(posedge clock) disable iff (!rst_b)
    clockEnable && cmpMatch[2]
    |=> st.flagsExt[`BIT_CMP_C1])
    else $error("First timer compare C match did not set its flag");

  overflow_flag_a: assert property ( // R12
    @(posedge clock) disable iff (!rst_b)
    clockEnable && t1Overflow
    |=> st.flagsMain[`BIT_OVF])
    else $error("Overflow pulse did not set its flag");

  pin_toggle_a: assert property ( // R02
    @(posedge clock) disable iff (!rst_b)
    clockEnable && cmpMatch[0] && st.toggleEn[0]
    |=> compareOutputPin[0] != $past(compareOutputPin[0]))
    else $error("Compare match did not toggle its output pin");

  ext_irq_line_a: assert property ( // R16
    @(posedge clock) disable iff (!rst_b)
    clockEnable && !legacyOn
    |=> irqLinesExt == $past(st.flagsExt & st.maskExt))
    else $error("Extended request lines differ from flags and mask");

  legacy_write_a: assert property ( // R15
    @(posedge clock) disable iff (!rst_b)
    clockEnable && legacyOn && st.wrPending && st.wrIndex == `IDX_EXT_MASK
    |=> st.maskExt == $past(st.maskExt))
    else $error("Extended mask written in legacy mode");

  write_clear_a: assert property ( // R18
    @(posedge clock) disable iff (!rst_b)
    clockEnable && st.wrPending && st.wrIndex == `IDX_FLAGS && evMain == 8'h00
    |=> (st.flagsMain & $past(hwdata[7:0])) == 8'h00)
    else $error("Written one did not clear its flag");
endmodule

/* File: sim/cpu_vector_model.sv */
// Core-side model: applies global gating and executes interrupt vectors
module cpu_vector_model #(
  parameter int DELAY = 2
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic globalEnable,
  input wire logic [7:0] irqLinesMain,
  input wire logic [7:0] irqLinesExt,
  output logic [7:0] vectorAckMain,
  output logic [7:0] vectorAckExt
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // Lowest pending main line wins, ext lines only when no main line is pending; the ack is a one-cycle pulse
  always @(posedge clock) begin
    vectorAckMain <= 8'h00;
    vectorAckExt <= 8'h00;
    if (!rst_b) begin
      cnt <= 0;
    end else if (globalEnable && ((irqLinesMain | irqLinesExt) != 8'h00)) begin
      if (cnt == DELAY) begin
        cnt <= 0;
        if (irqLinesMain != 8'h00) begin
          vectorAckMain <= irqLinesMain & (~irqLinesMain + 8'h01);
        end else begin
          vectorAckExt <= irqLinesExt & (~irqLinesExt + 8'h01);
        end
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule

/* File: sim/timer16_compare_capture_irq_mask_test.sv */
// Register-level testbench for the timer compare/capture block
module timer16_compare_capture_irq_mask_test;
  timeunit 1ns;
  timeprecision 1ps;
  import timer16_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic clockEnable = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic legacyMode = 1'b0;
  word16_t t1Count = 16'hFFFF;
  word16_t t3Count = 16'hFFFF;
  logic t1Tick = 1'b0;
  logic t3Tick = 1'b0;
  logic t1Overflow = 1'b0;
  logic t3Overflow = 1'b0;
  logic t1CapturePin = 1'b1;
  logic t3CapturePin = 1'b0;
  logic comparatorOut = 1'b1;
  logic globalEnable = 1'b0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] vectorAckMain;
  logic [7:0] vectorAckExt;
  logic [5:0] compareOutputPin;
  word16_t t1TopValue;
  word16_t t3TopValue;
  logic [7:0] irqLinesMain;
  logic [7:0] irqLinesExt;
  logic irq;
  word16_t v;
  int n;
  int failures = 0;
  int check_count = 0;
  // Flag register and bit of each compare channel
  logic [5:0] fIdx [6] = '{6'h12, 6'h12, 6'h13, 6'h13, 6'h13, 6'h13};
  logic [7:0] fBit [6] = '{8'h10, 8'h08, 8'h01, 8'h10, 8'h08, 8'h02};

  always #4 clock = ~clock;

  timer16_compare_capture uut (
    .clock(clock), .rst_b(rst_b), .clockEnable(clockEnable), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .legacyMode(legacyMode),
    .t1Count(t1Count), .t3Count(t3Count), .t1Tick(t1Tick), .t3Tick(t3Tick),
    .t1Overflow(t1Overflow), .t3Overflow(t3Overflow), .t1CapturePin(t1CapturePin),
    .t3CapturePin(t3CapturePin), .comparatorOut(comparatorOut),
    .vectorAckMain(vectorAckMain), .vectorAckExt(vectorAckExt),
    .compareOutputPin(compareOutputPin), .t1TopValue(t1TopValue), .t3TopValue(t3TopValue),
    .irqLinesMain(irqLinesMain), .irqLinesExt(irqLinesExt), .irq(irq)
  );

  cpu_vector_model #(.DELAY(2)) cpu (
    .clock(clock), .rst_b(rst_b), .globalEnable(globalEnable), .irqLinesMain(irqLinesMain),
    .irqLinesExt(irqLinesExt), .vectorAckMain(vectorAckMain), .vectorAckExt(vectorAckExt)
  );

  task automatic results;
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic waitReady;
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      results;
    end
  endtask

  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, idx, 2'h0};
    waitReady;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    waitReady;
    q = hrdata[7:0];
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, idx, d, q);
  endtask

  task automatic rd(input string what, input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    xfer(1'b0, idx, 8'h00, q);
    check(what, {8'h00, exp}, {8'h00, q});
  endtask

  task automatic tick(input word16_t c);
    @(posedge clock);
    t1Count <= c;
    t3Count <= c;
    t1Tick <= 1'b1;
    t3Tick <= 1'b1;
    @(posedge clock);
    t1Tick <= 1'b0;
    t3Tick <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    results;
  end

  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    check("top1 reset", 16'hFFFF, t1TopValue);
    rd("mask reset", 6'h10, 8'h00);
    rd("ext mask reset", 6'h11, 8'h00);
    rd("cmp hi reset", 6'h01, 8'h00);
    rd("unmapped", 6'h20, 8'h00);
    wr(6'h10, 8'hFF);
    rd("mask", 6'h10, 8'hFF);
    wr(6'h11, 8'hFF);
    rd("ext mask", 6'h11, 8'h3F);
    legacyMode <= 1'b1;
    repeat (3) @(posedge clock);
    wr(6'h11, 8'h00);
    rd("ext mask hidden", 6'h11, 8'h00);
    legacyMode <= 1'b0;
    repeat (3) @(posedge clock);
    rd("ext mask legacy", 6'h11, 8'h3F);
    wr(6'h15, 8'h3F);
    wr(6'h01, 8'h5A);
    wr(6'h02, 8'h77);
    rd("shared latch", 6'h03, 8'h5A);
    for (int k = 0; k < 6; k++) begin
      v = 16'h1357 + 16'(k) * 16'h1111;
      wr(6'(2 * k + 1), v[15:8]);
      wr(6'(2 * k), v[7:0]);
      rd("cmp hi", 6'(2 * k + 1), v[15:8]);
      tick(v);
      rd("cmp flag", fIdx[k], fBit[k]);
      check("line", {8'h00, fBit[k]}, {8'h00, (fIdx[k] == 6'h12) ? irqLinesMain : irqLinesExt});
      check("irq", 16'h0001, {15'h0, irq});
      check("pin", 16'h0001, {15'h0, compareOutputPin[k]});
      wr(fIdx[k], fBit[k]);
      rd("flag cleared", fIdx[k], 8'h00);
    end
    @(posedge clock);
    t1Overflow <= 1'b1;
    t3Overflow <= 1'b1;
    @(posedge clock);
    t1Overflow <= 1'b0;
    t3Overflow <= 1'b0;
    rd("t1 overflow", 6'h12, 8'h04);
    rd("t3 overflow", 6'h13, 8'h04);
    globalEnable <= 1'b1;
    n = 0;
    while (irq !== 1'b0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    globalEnable <= 1'b0;
    check("irq after vectors", 16'h0000, {15'h0, irq});
    rd("vector clear", 6'h12, 8'h00);
    rd("ext vector clear", 6'h13, 8'h00);
    clockEnable <= 1'b0;
    @(posedge clock);
    t1Overflow <= 1'b1;
    @(posedge clock);
    t1Overflow <= 1'b0;
    clockEnable <= 1'b1;
    rd("frozen flags", 6'h12, 8'h00);
    t1Count <= 16'hABCD;
    t1CapturePin <= 1'b0;
    repeat (8) @(posedge clock);
    rd("cap1 flag", 6'h12, 8'h20);
    check("cap1 line", 16'h0020, {8'h00, irqLinesMain});
    rd("cap1 lo", 6'h0C, 8'hCD);
    t1Count <= 16'h1122;
    t1CapturePin <= 1'b1;
    repeat (4) @(posedge clock);
    t1CapturePin <= 1'b0;
    repeat (8) @(posedge clock);
    rd("cap1 hi latched", 6'h0D, 8'hAB);
    rd("cap1 lo again", 6'h0C, 8'h22);
    rd("cap1 hi again", 6'h0D, 8'h11);
    wr(6'h12, 8'h20);
    wr(6'h14, 8'h02);
    t3Count <= 16'h3344;
    t3CapturePin <= 1'b1;
    repeat (8) @(posedge clock);
    rd("cap3 flag", 6'h13, 8'h20);
    check("cap3 line", 16'h0020, {8'h00, irqLinesExt});
    rd("cap3 lo", 6'h0E, 8'h44);
    rd("cap3 hi", 6'h0F, 8'h33);
    wr(6'h14, 8'h04);
    t1Count <= 16'h5AA5;
    comparatorOut <= 1'b0;
    repeat (8) @(posedge clock);
    rd("alt lo", 6'h0C, 8'hA5);
    rd("alt hi", 6'h0D, 8'h5A);
    wr(6'h14, 8'h0C);
    repeat (3) @(posedge clock);
    check("top1", 16'h5AA5, t1TopValue);
    check("top3", 16'hFFFF, t3TopValue);
    wr(6'h12, 8'h20);
    tick(16'h5AA5);
    rd("top flag", 6'h12, 8'h20);
    results;
  end
endmodule
